/* File: bench/irq_engine_model.sv */
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// request lines and channel engine stand-in
// ----------------------------------------
module irq_engine_model (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // stimulus from the bench
   input wire logic fire_i,
   input wire logic [7:0] fire_num_i,
   input wire logic pattern_i,
   // commands from the block
   input wire logic start_i,
   input wire logic abort_i,
   // lines towards the block
   output logic [255:0] irq_o,
   output logic pattern_match_o,
   // pulse tallies
   output logic [15:0] start_cnt_o,
   output logic [15:0] abort_cnt_o
);
   // one line high for one cycle per fire; the rest stay quiet
   always_ff @(posedge clk_i) begin
      irq_o <= '0;
      pattern_match_o <= pattern_i & ~rst_i;
      if (fire_i && !rst_i) begin
         irq_o[fire_num_i] <= 1'b1;
      end
   end

   // a command held two cycles counts twice, so a stuck pulse shows up
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         start_cnt_o <= 16'h0000;
         abort_cnt_o <= 16'h0000;
      end else begin
         start_cnt_o <= start_cnt_o + {15'h0000, start_i};
         abort_cnt_o <= abort_cnt_o + {15'h0000, abort_i};
      end
   end
endmodule // irq_engine_model

`default_nettype wire

/* File: bench/test_dma_event_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none

module test_dma_event_ctrl;
   // ----------------------------------------
   // signals
   // ----------------------------------------
   logic clk_i, rst_i, cyc, stb, we, ack, irq_line, start_p, abort_p, chon, aflag, fire, pat, pat_match, ce;
   logic [3:0] adr;
   logic [7:0] fire_num, s, a;
   logic [31:0] wdat, rdat, rdata;
   logic [255:0] irq_vec;
   logic [15:0] start_cnt, abort_cnt, exp_start, exp_abort;
   logic [7:0] sels [3] = '{8'h00, 8'h5A, 8'hFF};
   int num_errors = 0;
   int checks_done = 0;
   int cycles = 0;

   dma_event_ctrl #(.NUM_IRQ(256)) dut (
      .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
      .sel_i(4'hF), .dat_i(wdat), .dat_o(rdat), .ack_o(ack), .irq_i(irq_vec), .pattern_match_i(pat_match),
      .start_o(start_p), .abort_o(abort_p), .channel_on_o(chon), .channel_abort_flag_o(aflag), .irq_o(irq_line));

   irq_engine_model far_end (
      .clk_i(clk_i), .rst_i(rst_i), .fire_i(fire), .fire_num_i(fire_num), .pattern_i(pat), .start_i(start_p),
      .abort_i(abort_p), .irq_o(irq_vec), .pattern_match_o(pat_match), .start_cnt_o(start_cnt),
      .abort_cnt_o(abort_cnt));

   // 40 ns period
   initial begin
      clk_i = 1'b0;
      forever #20 clk_i = ~clk_i;
   end

   // ----------------------------------------
   // tasks
   // ----------------------------------------
   task automatic conclude();
      $display("checks %0d mismatches %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   task automatic check_word(input logic [31:0] got, input logic [31:0] exp, input string what);
      checks_done++;
      if (got !== exp) begin
         num_errors++;
         $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
      end
   endtask

   task automatic check_bit(input logic got, input logic exp, input string what);
      check_word({31'h0000_0000, got}, {31'h0000_0000, exp}, what);
   endtask

   task automatic check_counts();
      check_word({16'h0000, start_cnt}, {16'h0000, exp_start}, "start pulses");
      check_word({16'h0000, abort_cnt}, {16'h0000, exp_abort}, "abort pulses");
   endtask

   // classic cycle: hold everything until ack is sampled, then release for a cycle
   task automatic wb_xfer(input logic w, input logic [3:0] ad, input logic [31:0] d);
      int n;
      n = 0;
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= ad;
      wdat <= d;
      @(posedge clk_i);
      while (ack !== 1'b1 && n < 20) begin
         @(posedge clk_i);
         n++;
      end
      if (n >= 20) begin
         num_errors++;
         $display("unexpected at %0t: no bus answer", $time);
      end
      rdata = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk_i);
   endtask

   task automatic wr(input logic [3:0] ad, input logic [31:0] d);
      wb_xfer(1'b1, ad, d);
      repeat (3) @(posedge clk_i);
   endtask

   task automatic rd(input logic [3:0] ad);
      wb_xfer(1'b0, ad, 32'h0000_0000);
   endtask

   // the line rises one cycle after the request and the pulse two later
   task automatic fire_irq(input logic [7:0] n);
      fire <= 1'b1;
      fire_num <= n;
      @(posedge clk_i);
      fire <= 1'b0;
      repeat (4) @(posedge clk_i);
   endtask

   task automatic pulse_pattern();
      pat <= 1'b1;
      @(posedge clk_i);
      pat <= 1'b0;
      repeat (4) @(posedge clk_i);
   endtask

   // a hang ends the run as a mismatch
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 4000) begin
         num_errors++;
         $display("unexpected at %0t: run too long", $time);
         conclude();
      end
   end

   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      rst_i = 1'b1;
      {cyc, stb, we, fire, pat} = 5'b00000;
      ce = 1'b1;
      adr = 4'h0;
      wdat = 32'h0000_0000;
      fire_num = 8'h00;
      exp_start = 16'h0000;
      exp_abort = 16'h0000;
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      rd(dma_event_pkg::ADDR_EVENT_CONTROL);
      check_word(rdata, 32'h00FF_FF00, "control after reset");
      rd(dma_event_pkg::ADDR_IRQ_STATUS);
      check_word(rdata, 32'h0000_0000, "status after reset");
      rd(dma_event_pkg::ADDR_IRQ_MASK);
      check_word(rdata, 32'h0000_0000, "mask after reset");
      rd(4'h2);
      check_word(rdata, 32'h0000_0000, "unmapped read");
      check_bit(chon, 1'b0, "channel on after reset");
      $display("test reset done");

      // both strobes at once: abort wins, reserved and strobe bits read zero
      wr(dma_event_pkg::ADDR_EVENT_CONTROL, 32'hFFFF_FFFF);
      exp_abort++;
      rd(dma_event_pkg::ADDR_EVENT_CONTROL);
      check_word(rdata, 32'h00FF_FF38, "control readback");
      check_counts();
      $display("test readback done");

      // boundary and middle selections, near misses and disabled paths
      for (int i = 0; i < 3; i++) begin
         s = sels[i];
         a = s ^ 8'h01;
         wr(dma_event_pkg::ADDR_EVENT_CONTROL, {8'h00, a, s, 8'h10});
         fire_irq(s);
         exp_start++;
         check_counts();
         fire_irq(s ^ 8'h80);
         check_counts();
         fire_irq(a);
         check_counts();
         wr(dma_event_pkg::ADDR_EVENT_CONTROL, {8'h00, a, s, 8'h08});
         fire_irq(s);
         check_counts();
         fire_irq(a);
         exp_abort++;
         check_counts();
         check_bit(aflag, 1'b1, "abort flag set");
         wr(dma_event_pkg::ADDR_CHANNEL_CTRL, 32'h0000_0002);
         check_bit(aflag, 1'b0, "abort flag cleared");
      end
      $display("test irq select done");

      wr(dma_event_pkg::ADDR_EVENT_CONTROL, 32'h0000_0080);
      exp_start++;
      check_counts();
      wr(dma_event_pkg::ADDR_EVENT_CONTROL, 32'h0000_0040);
      exp_abort++;
      check_counts();
      $display("test strobes done");

      // clock enable low freezes the block, so a matching irq starts nothing
      wr(dma_event_pkg::ADDR_EVENT_CONTROL, 32'h0000_1110);
      ce <= 1'b0;
      fire_irq(8'h11);
      ce <= 1'b1;
      check_counts();
      fire_irq(8'h11);
      exp_start++;
      check_counts();
      $display("test clock enable done");

      wr(dma_event_pkg::ADDR_CHANNEL_CTRL, 32'h0000_0001);
      check_bit(chon, 1'b1, "channel on set");
      wr(dma_event_pkg::ADDR_EVENT_CONTROL, 32'h0000_0000);
      pulse_pattern();
      check_counts();
      check_bit(chon, 1'b1, "channel on kept");
      wr(dma_event_pkg::ADDR_EVENT_CONTROL, 32'h0000_0020);
      pulse_pattern();
      exp_abort++;
      check_counts();
      check_bit(chon, 1'b0, "channel on cleared");
      $display("test pattern done");

      // sticky status, masked then unmasked, then write-one clear
      rd(dma_event_pkg::ADDR_IRQ_STATUS);
      check_word(rdata, 32'h0000_0007, "status bits");
      check_bit(irq_line, 1'b0, "irq masked");
      wr(dma_event_pkg::ADDR_IRQ_MASK, 32'h0000_0004);
      check_bit(irq_line, 1'b1, "irq unmasked");
      wr(dma_event_pkg::ADDR_IRQ_STATUS, 32'h0000_0007);
      rd(dma_event_pkg::ADDR_IRQ_STATUS);
      check_word(rdata, 32'h0000_0000, "status cleared");
      check_bit(irq_line, 1'b0, "irq dropped");
      $display("test interrupt done");
      conclude();
   end
endmodule // test_dma_event_ctrl

`default_nettype wire

/* File: src/dma_event_ctrl.sv */
// Chosen here: the register offsets and register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - bits 15..8 select the interrupt number 0..255 that starts a channel transfer.
// - bits 23..16 select the interrupt number 0..255 that aborts a transfer and sets the abort flag.
// - bit 4 enables the start interrupt; when clear, that interrupt starts nothing.
// - bit 3 enables the abort interrupt; when clear, that interrupt ends nothing.
// - writing one to bit 7 starts a transfer at once unless an abort lands in the same cycle, and bit 7 always reads zero.
// - writing one to bit 6 aborts the transfer in progress, and bit 6 always reads zero.
// - with bit 5 set a pattern match while channel_on is set aborts the transfer and clears channel_on, else it does nothing.
// - bits 31..24 and 2..0 read as zero and ignore writes.
module dma_event_ctrl #(
   parameter int NUM_IRQ = 256
) (
   // clock, reset, enable
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   // wishbone slave
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [3:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   // event sources
   input wire logic [NUM_IRQ-1:0] irq_i,
   input wire logic pattern_match_i,
   // channel engine commands
   output logic start_o,
   output logic abort_o,
   output logic channel_on_o,
   output logic channel_abort_flag_o,
   // interrupt
   output logic irq_o
);

   // ----------------------------------------
   // state
   // ----------------------------------------
   dma_event_pkg::event_cfg_t cfg_reg;
   dma_event_pkg::event_cmd_t cmd_next;
   logic [dma_event_pkg::STAT_W-1:0] status_reg;
   logic [dma_event_pkg::STAT_W-1:0] mask_reg;
   logic channel_on_reg;
   logic abort_flag_reg;
   logic start_reg;
   logic abort_reg;
   logic irq_reg;
   logic [31:0] rdata_reg;
   logic wr;
   logic rd;
   logic start_hit;
   logic abort_hit;
   logic force_wr;
   logic abort_wr;
   logic [31:0] wmask;
   logic [31:0] ctl_word;
   logic [31:0] ctl_new;
   logic [dma_event_pkg::STAT_W-1:0] stat_set;

   // ----------------------------------------
   // bus handshake
   // ----------------------------------------
   wb_slave_port u_port (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .ce_i(ce_i),
      .cyc_i(cyc_i),
      .stb_i(stb_i),
      .we_i(we_i),
      .ack_o(ack_o),
      .wr_o(wr),
      .rd_o(rd)
   );

   // byte-lane mask from sel
   assign wmask = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};

   // ----------------------------------------
   // interrupt matching
   // ----------------------------------------
   irq_matcher #(
      .NUM_IRQ(NUM_IRQ),
      .SEL_W(dma_event_pkg::IRQ_NUM_W)
   ) u_start_match (
      .irq_i(irq_i),
      .sel_i(cfg_reg.start_sel),
      .enable_i(cfg_reg.start_en),
      .hit_o(start_hit)
   );

   irq_matcher #(
      .NUM_IRQ(NUM_IRQ),
      .SEL_W(dma_event_pkg::IRQ_NUM_W)
   ) u_abort_match (
      .irq_i(irq_i),
      .sel_i(cfg_reg.abort_sel),
      .enable_i(cfg_reg.abort_en),
      .hit_o(abort_hit)
   );

   // ----------------------------------------
   // control register image
   // ----------------------------------------
   // strobes never stored, so they read back as zero
   always_comb begin
      ctl_word = '0;
      ctl_word[dma_event_pkg::ABORT_SEL_LSB +: dma_event_pkg::IRQ_NUM_W] = cfg_reg.abort_sel;
      ctl_word[dma_event_pkg::START_SEL_LSB +: dma_event_pkg::IRQ_NUM_W] = cfg_reg.start_sel;
      ctl_word[dma_event_pkg::PATTERN_EN_BIT] = cfg_reg.pattern_en;
      ctl_word[dma_event_pkg::START_EN_BIT] = cfg_reg.start_en;
      ctl_word[dma_event_pkg::ABORT_EN_BIT] = cfg_reg.abort_en;
   end

   // unimplemented bits drop out through the write mask
   assign ctl_new = (ctl_word & ~(wmask & dma_event_pkg::WRITE_MASK))
      | (dat_i & wmask & dma_event_pkg::WRITE_MASK);

   assign force_wr = wr && adr_i == dma_event_pkg::ADDR_EVENT_CONTROL && sel_i[0]
      && dat_i[dma_event_pkg::FORCE_BIT];
   assign abort_wr = wr && adr_i == dma_event_pkg::ADDR_EVENT_CONTROL && sel_i[0]
      && dat_i[dma_event_pkg::ABORT_BIT];

   // ----------------------------------------
   // configuration fields
   // ----------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cfg_reg.abort_sel <= dma_event_pkg::SEL_RESET;
         cfg_reg.start_sel <= dma_event_pkg::SEL_RESET;
         cfg_reg.pattern_en <= 1'b0;
         cfg_reg.start_en <= 1'b0;
         cfg_reg.abort_en <= 1'b0;
      end else if (ce_i && wr && adr_i == dma_event_pkg::ADDR_EVENT_CONTROL) begin
         cfg_reg.abort_sel <= ctl_new[dma_event_pkg::ABORT_SEL_LSB +: dma_event_pkg::IRQ_NUM_W];
         cfg_reg.start_sel <= ctl_new[dma_event_pkg::START_SEL_LSB +: dma_event_pkg::IRQ_NUM_W];
         cfg_reg.pattern_en <= ctl_new[dma_event_pkg::PATTERN_EN_BIT];
         cfg_reg.start_en <= ctl_new[dma_event_pkg::START_EN_BIT];
         cfg_reg.abort_en <= ctl_new[dma_event_pkg::ABORT_EN_BIT];
      end
   end

   // ----------------------------------------
   // command generation
   // ----------------------------------------
   // abort wins over start when both land in one cycle
   always_comb begin
      cmd_next.pattern_abort = cfg_reg.pattern_en & pattern_match_i & channel_on_reg;
      cmd_next.abort = abort_hit | abort_wr | cmd_next.pattern_abort;
      cmd_next.start = (start_hit | force_wr) & ~cmd_next.abort;
   end

   // one-cycle command pulses to the channel engine
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         start_reg <= 1'b0;
         abort_reg <= 1'b0;
      end else if (ce_i) begin
         start_reg <= cmd_next.start;
         abort_reg <= cmd_next.abort;
      end
   end

   // ----------------------------------------
   // channel_on and abort flag
   // ----------------------------------------
   // pattern abort turns the channel off; the clear-over-set is fine
   // here because a hardware clear is the documented effect
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         channel_on_reg <= 1'b0;
      end else if (ce_i) begin
         if (cmd_next.pattern_abort) begin
            channel_on_reg <= 1'b0;
         end else if (wr && adr_i == dma_event_pkg::ADDR_CHANNEL_CTRL && sel_i[0]) begin
            channel_on_reg <= dat_i[dma_event_pkg::CHON_BIT];
         end
      end
   end

   // abort flag: set by the abort interrupt, cleared by writing one; set wins
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         abort_flag_reg <= 1'b0;
      end else if (ce_i) begin
         if (abort_hit) begin
            abort_flag_reg <= 1'b1;
         end else if (wr && adr_i == dma_event_pkg::ADDR_CHANNEL_CTRL && sel_i[0]
               && dat_i[dma_event_pkg::CHON_BIT + 1]) begin
            abort_flag_reg <= 1'b0;
         end
      end
   end

   // ----------------------------------------
   // interrupt status and mask
   // ----------------------------------------
   assign stat_set = {cmd_next.pattern_abort, cmd_next.abort, cmd_next.start};

   // sticky bits, write one to clear, a new event beats the clear
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         status_reg <= '0;
      end else if (ce_i) begin
         if (wr && adr_i == dma_event_pkg::ADDR_IRQ_STATUS && sel_i[0]) begin
            status_reg <= (status_reg & ~dat_i[dma_event_pkg::STAT_W-1:0]) | stat_set;
         end else begin
            status_reg <= status_reg | stat_set;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mask_reg <= '0;
      end else if (ce_i && wr && adr_i == dma_event_pkg::ADDR_IRQ_MASK && sel_i[0]) begin
         mask_reg <= dat_i[dma_event_pkg::STAT_W-1:0];
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_reg <= 1'b0;
      end else if (ce_i) begin
         irq_reg <= |((status_reg | stat_set) & mask_reg);
      end
   end

   // ----------------------------------------
   // read data
   // ----------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rdata_reg <= '0;
      end else if (ce_i && cyc_i && stb_i && !ack_o) begin
         if (adr_i == dma_event_pkg::ADDR_EVENT_CONTROL) begin
            rdata_reg <= ctl_word;
         end else if (adr_i == dma_event_pkg::ADDR_IRQ_STATUS) begin
            rdata_reg <= {{(32-dma_event_pkg::STAT_W){1'b0}}, status_reg};
         end else if (adr_i == dma_event_pkg::ADDR_IRQ_MASK) begin
            rdata_reg <= {{(32-dma_event_pkg::STAT_W){1'b0}}, mask_reg};
         end else if (adr_i == dma_event_pkg::ADDR_CHANNEL_CTRL) begin
            rdata_reg <= {30'h0, abort_flag_reg, channel_on_reg};
         end else begin
            rdata_reg <= '0; // unmapped reads zero
         end
      end
   end

   assign dat_o = rdata_reg;
   assign start_o = start_reg;
   assign abort_o = abort_reg;
   assign channel_on_o = channel_on_reg;
   assign channel_abort_flag_o = abort_flag_reg;
   assign irq_o = irq_reg;

   // ----------------------------------------
   // assertions
   // ----------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   a_start_on_match: assert property (ce_i && cfg_reg.start_en && irq_i[cfg_reg.start_sel] && !cmd_next.abort
      |=> start_o) else $error("enabled start irq did not start");
   a_abort_on_match: assert property (ce_i && cfg_reg.abort_en && irq_i[cfg_reg.abort_sel]
      |=> abort_o && channel_abort_flag_o) else $error("abort irq missed");
   a_start_gated_off: assert property (ce_i && !cfg_reg.start_en && !force_wr
      |=> !start_o) else $error("start without enable");
   a_abort_gated_off: assert property (ce_i && !cfg_reg.abort_en && !abort_wr && !cmd_next.pattern_abort
      |=> !abort_o) else $error("abort without enable");
   a_force_starts: assert property (ce_i && force_wr && !cmd_next.abort
      |=> start_o) else $error("force write did not start");
   a_abort_write: assert property (ce_i && abort_wr |=> abort_o)
      else $error("abort write did not abort");
   a_pattern_abort: assert property (ce_i && cfg_reg.pattern_en && pattern_match_i && channel_on_o
      |=> abort_o && !channel_on_o) else $error("pattern abort failed");
   a_reserved_zero: assert property (ack_o && !we_i && $past(adr_i) == dma_event_pkg::ADDR_EVENT_CONTROL
      |-> dat_o[31:24] == 8'h_00 && dat_o[7:6] == 2'b00 && dat_o[2:0] == 3'b000)
      else $error("reserved bits read nonzero");
   a_reset_values: assert property ($past(rst_i) && !rst_i
      |-> cfg_reg.start_sel == dma_event_pkg::SEL_RESET && !cfg_reg.start_en && !start_o)
      else $error("bad reset value");

   c_irq_start: cover property (start_o && !force_wr);
   c_irq_abort: cover property (abort_o ##1 channel_abort_flag_o);
   c_pattern: cover property (cmd_next.pattern_abort);
   c_interrupt: cover property (irq_o);

endmodule // dma_event_ctrl
`default_nettype wire

/* File: src/dma_event_pkg.sv */
package dma_event_pkg;

   // ----------------------------------------
   // register map
   // ----------------------------------------
   localparam logic [3:0] ADDR_EVENT_CONTROL = 4'h0;
   localparam logic [3:0] ADDR_IRQ_STATUS = 4'h4;
   localparam logic [3:0] ADDR_IRQ_MASK = 4'h8;
   localparam logic [3:0] ADDR_CHANNEL_CTRL = 4'hC;

   // ----------------------------------------
   // channel_event_control fields
   // ----------------------------------------
   localparam int ABORT_SEL_LSB = 16;
   localparam int START_SEL_LSB = 8;
   localparam int FORCE_BIT = 7;
   localparam int ABORT_BIT = 6;
   localparam int PATTERN_EN_BIT = 5;
   localparam int START_EN_BIT = 4;
   localparam int ABORT_EN_BIT = 3;
   localparam int IRQ_NUM_W = 8;
   localparam logic [7:0] SEL_RESET = 8'h_FF;
   localparam logic [31:0] WRITE_MASK = 32'h_00FF_FF38;

   // ----------------------------------------
   // status bits: 0 start issued, 1 abort issued, 2 pattern abort
   // ----------------------------------------
   localparam int STAT_W = 3;
   localparam int ST_START = 0;
   localparam int ST_ABORT = 1;
   localparam int ST_PATTERN = 2;

   // channel_ctrl: bit 0 channel_on (software set, pattern abort clears)
   localparam int CHON_BIT = 0;

   // ----------------------------------------
   // carrier types
   // ----------------------------------------
   typedef struct packed {
      logic [7:0] abort_sel;
      logic [7:0] start_sel;
      logic pattern_en;
      logic start_en;
      logic abort_en;
   } event_cfg_t;

   typedef struct packed {
      logic start;
      logic abort;
      logic pattern_abort;
   } event_cmd_t;

   typedef enum logic [1:0] {
      WB_IDLE = 2'b00,
      WB_ACK = 2'b01
   } wb_state_t;

endpackage

/* File: src/irq_matcher.sv */
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// decoding one selected interrupt line out of the request vector
// ----------------------------------------
module irq_matcher #(
   parameter int NUM_IRQ = 256,
   parameter int SEL_W = 8
) (
   // request lines and selection
   input wire logic [NUM_IRQ-1:0] irq_i,
   input wire logic [SEL_W-1:0] sel_i,
   input wire logic enable_i,
   // result
   output logic hit_o
);

   // only the exact selected number counts, and only when enabled
   assign hit_o = enable_i & irq_i[sel_i];

endmodule // irq_matcher
`default_nettype wire

/* File: src/wb_slave_port.sv */
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// classic wishbone handshake: one-cycle registered ack
// ----------------------------------------
module wb_slave_port (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   // bus
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   output logic ack_o,
   // access strobes, valid in the acking cycle
   output logic wr_o,
   output logic rd_o
);

   dma_event_pkg::wb_state_t state_reg;

   // ack is raised once per request, dropped the cycle after
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_reg <= dma_event_pkg::WB_IDLE;
      end else if (ce_i) begin
         case (state_reg)
            dma_event_pkg::WB_IDLE: begin
               if (cyc_i && stb_i) begin
                  state_reg <= dma_event_pkg::WB_ACK;
               end
            end
            default: begin
               state_reg <= dma_event_pkg::WB_IDLE;
            end
         endcase
      end
   end

   assign ack_o = (state_reg == dma_event_pkg::WB_ACK);
   assign wr_o = ack_o & ce_i & we_i;
   assign rd_o = ack_o & ce_i & ~we_i;

endmodule // wb_slave_port
`default_nettype wire
